// ==== watchdog_reset_control.sv ====
// reset combiner with delay stretch and watchdog timer behind an apb slave
//
// Behaviour
// RULE1: internal reset returns all registers to initial values; release pulses vector start. The code leaves the reset flags to power-on reset.
// RULE2: any active source clears the reset output asynchronously, no clock needed.
// RULE3: after all sources go inactive, reset is stretched by fuse-selected delay.
// RULE4: power-on, pin, watchdog, low-supply and test-chain sources all reset everything. The code resets the reset flags on power-on only.
// RULE5: low reset pin resets without clock; its release starts the delay.
// RULE6: device stays in reset while the test-chain reset bit is one.
// RULE7: enabled low-supply detector resets at once; delay runs after it clears.
// RULE8: power-on detection reasserts reset at once, whatever the delay state.
// RULE9: watchdog reset is a one-cycle pulse; delay starts as it ends.
// RULE10: watchdog counts 128 kHz oscillator ticks and acts at selected count.
// RULE11: restart command clears watchdog counter; software restarts before expiry.
// RULE12: interrupt mode raises a request on expiry that also wakes from sleep.
// RULE13: system reset mode resets the device on expiry.
// RULE14: combined mode interrupts first, then falls back to reset mode.
// RULE15: always-on fuse forces reset mode: reset enable one, irq enable zero.
// RULE16: clearing reset enable or changing prescaler needs the timed sequence.
// RULE17: software opens the sequence writing change and reset enable both one.
// RULE18: new settings written with change clear within four cycles are accepted.
// RULE19: time-outs span about 16 ms up to 8 s.
// RULE20: a fired watchdog reset leaves the watchdog enabled after reset.
// RULE21: software should clear the dog flag and reset enable at start-up.
// RULE22: while dog reset flag is set, reset enable reads and acts as one.
// RULE23: hardware clears the change bit four cycles after it was set.
// RULE24: prescaler codes give 2048 doubling to 1048576 ticks; six codes reserved.
// RULE25: vector entry in combined mode clears irq flag and irq enable.
// RULE26: watchdog oscillator and system logic cross safely between their rates.
//
// The APB register port and the register addresses were decided locally.
`include "watchdog_reset_control_defs.svh"
module watchdog_reset_control
   import watchdog_reset_control_pkg::*;
#(
   parameter int DOG_TICK_DIV  = `PCLK_HZ / `DOG_OSC_HZ,
   parameter int DOG_BASE_LOG2 = `DOG_BASE_LOG2,
   parameter int DELAY_BASE    = `DELAY_BASE_CYCLES
) (
   // apb clock and power-on reset
   input  wire logic              pclk,
   input  wire logic              presetn,
   // apb slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [`ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   // reset sources
   input  wire logic              rst_pin_n,
   input  wire logic              bod_low,
   input  wire logic              jtag_reset,
   // fuses
   input  wire fuse_s             fuses,
   // reset and watchdog outputs
   output logic                   sys_rst_n,
   output logic                   reset_vector_go,
   output logic                   dog_irq,
   output logic                   dog_wake
);

   // ----------------------------------------------------------------
   // parameter checks
   // ----------------------------------------------------------------
   if (DOG_TICK_DIV < 2 || DOG_TICK_DIV >= (1 << `TICK_W)) begin : g_div
      $error("DOG_TICK_DIV out of range");
   end
   if (DOG_BASE_LOG2 < 1 || DOG_BASE_LOG2 + 9 >= `DOG_CNT_W) begin : g_log
      $error("DOG_BASE_LOG2 out of range");
   end
   if (DELAY_BASE < 1 || (DELAY_BASE << 6) >= (1 << `DELAY_W)) begin : g_dly
      $error("DELAY_BASE out of range");
   end

   // ----------------------------------------------------------------
   // functions
   // ----------------------------------------------------------------
   function automatic logic [1:0] reg_sel(input logic [`ADDR_W-1:0] a);
      case (a)
         `DOG_CTRL_OFFSET:    reg_sel = 2'h1;
         `RESET_FLAGS_OFFSET: reg_sel = 2'h2;
         `DOG_CMD_OFFSET:     reg_sel = 2'h3;
         default:             reg_sel = 2'h0;
      endcase
   endfunction

   // reserved prescaler codes behave as the longest time-out
   function automatic dcnt_t dog_limit(input logic [3:0] code);
      logic [3:0] k;
      k = (code > `DOG_MAX_CODE) ? `DOG_MAX_CODE : code;
      dog_limit = dcnt_t'(dcnt_t'(1) << (DOG_BASE_LOG2 + int'(k)));
   endfunction

   function automatic delay_t delay_limit(input logic [1:0] startup_time_fuse);
      delay_limit = delay_t'(DELAY_BASE << (2 * int'(startup_time_fuse)));
   endfunction

   // ----------------------------------------------------------------
   // reset source combination
   // ----------------------------------------------------------------
   flag_dom_s    f;
   flag_dom_s    next_f;
   rst_seq_s     rs;
   rst_seq_s     next_rs;
   core_s        c;
   core_s        next_c;
   logic         bod_on;
   logic         src_async_n;
   logic [2:0]   src_q;
   logic         dog_fire;
   reset_flags_s flag_clr;

   assign bod_on = (fuses.low_supply_level != `BOD_OFF_CODE);

   // RULE4: five sources merged
   // RULE2: any source clears reset output at once
   // RULE5: pin low path is clockless
   // RULE6: test chain held reset
   // RULE7: low supply immediate reset
   // RULE8: power-on asserts with no delay
   assign src_async_n = presetn & rst_pin_n & ~jtag_reset
                      & ~(bod_on & bod_low) & ~f.dog_pulse;

   level_sync3 #(
      .W (3)
   ) u_src_sync (
      .clk   (pclk),
      .rst_n (presetn),
      .d     ({~rst_pin_n, bod_low, jtag_reset}),
      .q     (src_q)
   );

   // ----------------------------------------------------------------
   // reset flags and watchdog pulse, reset by power-on only
   // ----------------------------------------------------------------
   always_comb begin
      next_f = f;
      // RULE9: one-cycle watchdog reset pulse
      next_f.dog_pulse = dog_fire;
      next_f.flags = f.flags & ~flag_clr;
      // flag sets win over a clearing write in the same cycle
      if (src_q[2]) next_f.flags.ext = 1'b1;
      if (src_q[1] && bod_on) next_f.flags.low_supply_detector = 1'b1;
      if (src_q[0]) next_f.flags.jtag = 1'b1;
      // RULE20: dog flag survives the reset it caused
      if (dog_fire) next_f.flags.dog = 1'b1;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         f.flags     <= `RESET_FLAGS_RESET;
         f.dog_pulse <= 1'b0;
      end else begin
         f <= next_f;
      end
   end

   // ----------------------------------------------------------------
   // delay stretch sequence
   // ----------------------------------------------------------------
   always_comb begin
      next_rs        = rs;
      next_rs.stage1 = 1'b1;
      next_rs.stage2 = rs.stage1;
      next_rs.vec_go = 1'b0;
      case (rs.phase)
         RST_HOLD: begin
            if (rs.stage2) begin
               next_rs.phase = RST_STRETCH;
               next_rs.cnt   = '0;
            end
         end
         // RULE3: fuse-selected stretch after release
         RST_STRETCH: begin
            if (rs.cnt == delay_limit(fuses.startup_time) - 1'b1) begin
               next_rs.phase     = RST_RUN;
               next_rs.sys_rst_n = 1'b1;
               // RULE1: start from the reset vector
               next_rs.vec_go    = 1'b1;
            end else begin
               next_rs.cnt = rs.cnt + 1'b1;
            end
         end
         RST_RUN: begin
            next_rs.sys_rst_n = 1'b1;
         end
         default: begin
            next_rs.phase = RST_HOLD;
         end
      endcase
   end

   // the release is synchronised before the stretch count starts
   always_ff @(posedge pclk or negedge src_async_n) begin
      if (!src_async_n) begin
         rs.phase     <= RST_HOLD;
         rs.stage1    <= 1'b0;
         rs.stage2    <= 1'b0;
         rs.cnt       <= '0;
         rs.sys_rst_n <= 1'b0;
         rs.vec_go    <= 1'b0;
      end else begin
         rs <= next_rs;
      end
   end

   assign sys_rst_n       = rs.sys_rst_n;
   assign reset_vector_go = rs.vec_go;

   // ----------------------------------------------------------------
   // core: apb registers and watchdog, reset by the internal reset
   // ----------------------------------------------------------------
   logic       setup;
   logic       wr;
   logic [1:0] wsel;
   logic [7:0] wd;
   logic [3:0] wd_presc;
   logic       rst_eff;
   logic       irq_eff;
   logic       tick_en;
   logic       restart;
   logic       expire;
   logic       irq_set;

   assign setup    = psel & ~penable;
   assign wsel     = reg_sel(paddr);
   assign wr       = psel & penable & c.pready & pwrite & (wsel != 2'h0);
   assign wd       = pwdata[7:0];
   assign wd_presc = {wd[`CTRL_PRESC_HI_BIT], wd[`CTRL_PRESC_LO_MSB:0]};

   // RULE15: fuse locks reset enable high, irq enable low
   // RULE22: dog flag forces reset enable
   assign rst_eff = fuses.always_on | f.flags.dog | c.ctrl.rst_en;
   assign irq_eff = ~fuses.always_on & c.ctrl.irq_en;

   // RULE26: the oscillator is a tick enable on pclk, so no crossing
   assign tick_en = (c.tick == tick_t'(DOG_TICK_DIV - 1));
   assign restart = wr && wsel == 2'h3 && wd[`CMD_RESTART_BIT];

   // RULE10: act when the selected tick count is reached
   // RULE19: 16 ms to 8 s span
   // RULE24: doubling prescale codes
   assign expire = tick_en && !restart
                && (fuses.always_on | rst_eff | irq_eff)
                && c.cnt == dog_limit(c.ctrl.presc) - 1'b1;

   // RULE12: interrupt on expiry
   assign irq_set = expire & irq_eff;

   // RULE13: reset on expiry
   // RULE14: second expiry unserviced resets
   assign dog_fire = expire & rst_eff & (~irq_eff | c.ctrl.irq_flag);

   always_comb begin
      next_c         = c;
      flag_clr       = '0;
      next_c.pready  = setup;
      next_c.pslverr = setup & (wsel == 2'h0);
      next_c.prdata  = '0;
      if (setup) begin
         case (wsel)
            2'h1: next_c.prdata[7:0] = {c.ctrl.irq_flag, irq_eff,
                                        c.ctrl.presc[3], c.ctrl.change,
                                        rst_eff, c.ctrl.presc[2:0]};
            2'h2: next_c.prdata[4:0] = f.flags;
            default: next_c.prdata = '0;
         endcase
      end

      // RULE23: change bit closes four cycles after opening
      if (c.win != 3'h0) begin
         next_c.win = c.win - 1'b1;
      end

      if (wr && wsel == 2'h1) begin
         if (wd[`CTRL_IRQ_FLAG_BIT]) next_c.ctrl.irq_flag = 1'b0;
         next_c.ctrl.irq_en = wd[`CTRL_IRQ_EN_BIT];
         if (wd[`CTRL_CHANGE_BIT] && wd[`CTRL_RST_EN_BIT]) begin
            // RULE17: opening write
            next_c.win         = `CHANGE_WINDOW;
            next_c.ctrl.rst_en = 1'b1;
         end else if (c.win != 3'h0 && !wd[`CTRL_CHANGE_BIT]) begin
            // RULE18: accepted only inside the window
            next_c.ctrl.rst_en = wd[`CTRL_RST_EN_BIT];
            next_c.ctrl.presc  = wd_presc;
            next_c.win         = 3'h0;
         end else begin
            // RULE16: outside the sequence reset enable may only be set
            next_c.ctrl.rst_en = c.ctrl.rst_en | wd[`CTRL_RST_EN_BIT];
         end
      end
      next_c.ctrl.change = (next_c.win != 3'h0);

      // writing zero clears a reset flag
      if (wr && wsel == 2'h2) begin
         flag_clr = ~reset_flags_s'(wd[4:0]);
      end

      // RULE25: vector entry clears flag, and enable in combined mode
      if (wr && wsel == 2'h3 && wd[`CMD_VECTOR_BIT]) begin
         next_c.ctrl.irq_flag = 1'b0;
         if (rst_eff && irq_eff) next_c.ctrl.irq_en = 1'b0;
      end

      next_c.tick = tick_en ? '0 : c.tick + 1'b1;
      // RULE11: restart clears the counter
      if (restart || !(fuses.always_on | rst_eff | irq_eff)) begin
         next_c.cnt = '0;
      end else if (tick_en) begin
         next_c.cnt = expire ? '0 : c.cnt + 1'b1;
      end

      // hardware set wins over a clearing write
      if (irq_set) next_c.ctrl.irq_flag = 1'b1;
      next_c.irq  = next_c.ctrl.irq_flag & next_c.ctrl.irq_en
                  & ~fuses.always_on;
      next_c.wake = irq_set;
   end

   // RULE1: all registers back to initial values under internal reset
   always_ff @(posedge pclk or negedge rs.sys_rst_n) begin
      if (!rs.sys_rst_n) begin
         c.ctrl    <= `DOG_CTRL_RESET;
         c.win     <= '0;
         c.tick    <= '0;
         c.cnt     <= '0;
         c.pready  <= 1'b0;
         c.pslverr <= 1'b0;
         c.prdata  <= '0;
         c.irq     <= 1'b0;
         c.wake    <= 1'b0;
      end else begin
         c <= next_c;
      end
   end

   assign prdata   = c.prdata;
   assign pready   = c.pready;
   assign pslverr  = c.pslverr;
   assign dog_irq  = c.irq;
   assign dog_wake = c.wake;

endmodule

// ==== watchdog_reset_control_defs.svh ====
// offsets, field positions, reset values and timing counts of the reset/watchdog block
`ifndef WATCHDOG_RESET_CONTROL_DEFS_SVH
`define WATCHDOG_RESET_CONTROL_DEFS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define DOG_CTRL_OFFSET    12'h000
`define RESET_FLAGS_OFFSET 12'h004
`define DOG_CMD_OFFSET     12'h008
`define ADDR_W             12

// ----------------------------------------------------------------
// dog control field positions
// ----------------------------------------------------------------
`define CTRL_IRQ_FLAG_BIT  7
`define CTRL_IRQ_EN_BIT    6
`define CTRL_PRESC_HI_BIT  5
`define CTRL_CHANGE_BIT    4
`define CTRL_RST_EN_BIT    3
`define CTRL_PRESC_LO_MSB  2

// ----------------------------------------------------------------
// command register bits
// ----------------------------------------------------------------
`define CMD_RESTART_BIT    0
`define CMD_VECTOR_BIT     1

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define DOG_CTRL_RESET     8'h00
`define RESET_FLAGS_RESET  5'h01
`define BOD_OFF_CODE       3'h7

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define PCLK_HZ            125000000
`define DOG_OSC_HZ         128000
`define CHANGE_WINDOW      3'h4
`define DOG_BASE_LOG2      11
`define DOG_MAX_CODE       4'h9
`define DELAY_BASE_CYCLES  64
`define TICK_W             16
`define DOG_CNT_W          24
`define DELAY_W            20

`endif

// ==== watchdog_reset_control_pkg.sv ====
// types shared by the reset combiner and watchdog
`include "watchdog_reset_control_defs.svh"
package watchdog_reset_control_pkg;

   typedef logic [`TICK_W-1:0]    tick_t;
   typedef logic [`DOG_CNT_W-1:0] dcnt_t;
   typedef logic [`DELAY_W-1:0]   delay_t;

   typedef enum {
      RST_HOLD,
      RST_STRETCH,
      RST_RUN
   } rst_phase_e;

   typedef struct packed {
      logic       irq_flag;
      logic       irq_en;
      logic       change;
      logic       rst_en;
      logic [3:0] presc;
   } dog_ctrl_s;

   typedef struct packed {
      logic jtag;
      logic dog;
      logic low_supply_detector;
      logic ext;
      logic por;
   } reset_flags_s;

   typedef struct packed {
      logic       always_on;
      logic [1:0] startup_time;
      logic [2:0] low_supply_level;
   } fuse_s;

   typedef struct packed {
      dog_ctrl_s   ctrl;
      logic [2:0]  win;
      tick_t       tick;
      dcnt_t       cnt;
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
      logic        irq;
      logic        wake;
   } core_s;

   typedef struct packed {
      rst_phase_e  phase;
      logic        stage1;
      logic        stage2;
      delay_t      cnt;
      logic        sys_rst_n;
      logic        vec_go;
   } rst_seq_s;

   typedef struct packed {
      reset_flags_s flags;
      logic         dog_pulse;
   } flag_dom_s;

endpackage

// ==== level_sync3.sv ====
// three-stage level synchroniser that follows once stages two and three agree
module level_sync3
   import watchdog_reset_control_pkg::*;
#(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // levels
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } sync_s;

   sync_s r;
   sync_s next_r;

   if (W < 1) begin : g_w_chk
      $error("level_sync3: W must be at least 1");
   end

   always_comb begin
      next_r    = r;
      next_r.s1 = d;
      next_r.s2 = r.s1;
      next_r.s3 = r.s2;
      for (int i = 0; i < W; i++) begin
         if (r.s2[i] == r.s3[i]) begin
            next_r.q[i] = r.s3[i];
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign q = r.q;

endmodule

// ==== level_sync3_unused_marker.sv ====
// intentionally left as a comment-only file holding no logic

// ==== core_model.sv ====
// processor-side model: apb master issuing register writes and restarts
`include "watchdog_reset_control_defs.svh"
module core_model
   import watchdog_reset_control_pkg::*;
(
   // clock
   input  wire logic               pclk,
   // apb master side
   output logic                    psel,
   output logic                    penable,
   output logic                    pwrite,
   output logic [`ADDR_W-1:0]      paddr,
   output logic [31:0]             pwdata,
   input  wire logic [31:0]        prdata,
   input  wire logic               pready,
   input  wire logic               pslverr
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = '0;
      pwdata  = '0;
   end

   // one transfer; entered just after an edge, request held until pready
   task automatic xfer(input logic w, input logic [`ADDR_W-1:0] a,
                       input logic [31:0] d, output logic [31:0] rd,
                       output logic er);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule

// ==== watchdog_reset_control_checker.sv ====
// port-level assertions for the reset combiner and watchdog
`include "watchdog_reset_control_defs.svh"
module watchdog_reset_control_checker
   import watchdog_reset_control_pkg::*;
(
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pready,
   input  wire logic               rst_pin_n,
   input  wire logic               bod_low,
   input  wire logic               jtag_reset,
   input  wire fuse_s              fuses,
   input  wire logic               sys_rst_n,
   input  wire logic               reset_vector_go,
   input  wire logic               dog_irq,
   input  wire logic               dog_wake
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   property p_hold;
      !sys_rst_n |-> !pready && !dog_irq;
   endproperty
   a_hold: assert property (p_hold)
      else $error("bus or irq active in reset");

   property p_vec;
      reset_vector_go |-> $rose(sys_rst_n) ##1 !reset_vector_go;
   endproperty
   a_vec: assert property (p_vec)
      else $error("vector start not tied to reset release");

   property p_async;
      !rst_pin_n || jtag_reset |-> !sys_rst_n;
   endproperty
   a_async: assert property (p_async)
      else $error("pin or test reset did not hold reset");

   property p_bod;
      bod_low && fuses.low_supply_level != `BOD_OFF_CODE |-> !sys_rst_n;
   endproperty
   a_bod: assert property (p_bod)
      else $error("low supply did not hold reset");

   // stretch covers the two sync edges and the edge that starts the delay count
   property p_stretch;
      $rose(rst_pin_n) && !jtag_reset |-> !sys_rst_n [*3];
   endproperty
   a_stretch: assert property (p_stretch)
      else $error("reset released without stretch");

   property p_ready;
      psel && !penable && sys_rst_n && rst_pin_n && !jtag_reset
         |=> (pready || !sys_rst_n) ##1 !pready;
   endproperty
   a_ready: assert property (p_ready)
      else $error("pready not a single cycle after setup");

   property p_aon;
      fuses.always_on && $past(fuses.always_on) |-> !dog_irq;
   endproperty
   a_aon: assert property (p_aon)
      else $error("irq raised with always-on fuse");

   property p_wake;
      dog_wake |-> ##[0:2] (dog_irq || !sys_rst_n);
   endproperty
   a_wake: assert property (p_wake)
      else $error("wake without interrupt request");
endmodule

bind watchdog_reset_control watchdog_reset_control_checker chk_u (
   .pclk, .presetn, .psel, .penable, .pready, .rst_pin_n, .bod_low,
   .jtag_reset, .fuses, .sys_rst_n, .reset_vector_go, .dog_irq, .dog_wake);

// ==== tb_top.sv ====
// top-level bench for the reset combiner and watchdog
`include "watchdog_reset_control_defs.svh"
module tb_top
   import watchdog_reset_control_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic        w;
      logic [11:0] a;
      logic [31:0] d;
      logic        er;
   } row_s;
   logic               pclk = 1'b0;
   logic               presetn = 1'b0;
   logic               rst_pin_n = 1'b1;
   logic               bod_low = 1'b0;
   logic               jtag_reset = 1'b0;
   fuse_s              fuses = 6'h07;
   logic               psel, penable, pwrite, pready, pslverr;
   logic [`ADDR_W-1:0] paddr;
   logic [31:0]        pwdata, prdata;
   logic               sys_rst_n, reset_vector_go, dog_irq, dog_wake;
   int                 err_count = 0;
   int                 n_compared = 0;
   int                 wake_n = 0;
   int                 vec_n = 0;
   // reset values, a flag-clearing write, a refused write and an unmapped word
   row_s rows [9] = '{
      '{1'b0, 12'h004, 32'h01, 1'b0}, '{1'b1, 12'h004, 32'h00, 1'b0},
      '{1'b0, 12'h004, 32'h00, 1'b0}, '{1'b0, 12'h000, 32'h00, 1'b0},
      '{1'b1, 12'h000, 32'h07, 1'b0}, '{1'b0, 12'h000, 32'h00, 1'b0},
      '{1'b0, 12'h008, 32'h00, 1'b0}, '{1'b1, 12'h00c, 32'hff, 1'b1},
      '{1'b0, 12'h00c, 32'h00, 1'b1}};

   always #4 pclk = ~pclk;
   always @(posedge pclk) if (dog_wake === 1'b1) wake_n <= wake_n + 1;
   always @(posedge pclk) if (reset_vector_go === 1'b1) vec_n <= vec_n + 1;

   watchdog_reset_control #(.DOG_TICK_DIV(4), .DOG_BASE_LOG2(2),
      .DELAY_BASE(2)) dut_u (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .rst_pin_n, .bod_low, .jtag_reset, .fuses,
      .sys_rst_n, .reset_vector_go, .dog_irq, .dog_wake);
   core_model core_u (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr);

   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] rd;
      logic        er;
      core_u.xfer(1'b1, a, d, rd, er);
      @(posedge pclk);
   endtask
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
      logic [31:0] rd;
      logic        er;
      core_u.xfer(1'b0, a, 32'h0, rd, er);
      @(posedge pclk);
      chk(rd, e);
   endtask
   // bounded wait on the irq line or on the internal reset
   task automatic wait_for(input logic irq, input logic lv, input int lim);
      int i;
      i = 0;
      while ((irq ? dog_irq : sys_rst_n) !== lv && i < lim) begin
         @(posedge pclk);
         i++;
      end
      chk(32'(irq ? dog_irq : sys_rst_n), 32'(lv));
      @(posedge pclk);
   endtask
   // restart first: a fired reset leaves the dog running at the short code
   task automatic dog_off();
      wr(12'h008, 32'h01);
      wr(12'h004, 32'h00);
      wr(12'h000, 32'h18);
      wr(12'h000, 32'h00);
   endtask
   task automatic close_out();
      $display("compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial begin
      logic [31:0] rd;
      logic        er;
      int          n;
      int          lo;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      wait_for(1'b0, 1'b1, 200);
      foreach (rows[i]) begin
         core_u.xfer(rows[i].w, rows[i].a, rows[i].d, rd, er);
         @(posedge pclk);
         if (!rows[i].w) chk(rd, rows[i].d);
         chk(32'(er), 32'(rows[i].er));
      end
      wr(12'h000, 32'h18);
      wr(12'h000, 32'h01);
      rd_chk(12'h000, 32'h01);
      wr(12'h000, 32'h18);
      repeat (5) @(posedge pclk);
      wr(12'h008, 32'h01);
      rd_chk(12'h000, 32'h09);
      wr(12'h000, 32'h00);
      rd_chk(12'h000, 32'h09);
      repeat (12) begin
         wr(12'h008, 32'h01);
         chk(32'(sys_rst_n), 32'h1);
      end
      wait_for(1'b0, 1'b0, 200);
      wait_for(1'b0, 1'b1, 200);
      wr(12'h008, 32'h01);
      rd_chk(12'h004, 32'h08);
      rd_chk(12'h000, 32'h08);
      dog_off();
      rd_chk(12'h000, 32'h00);
      wr(12'h000, 32'h40);
      wait_for(1'b1, 1'b1, 200);
      chk(32'(wake_n > 0), 32'h1);
      rd_chk(12'h000, 32'hc0);
      wr(12'h000, 32'h80);
      wait_for(1'b1, 1'b0, 8);
      wr(12'h000, 32'h48);
      wait_for(1'b1, 1'b1, 200);
      chk(32'(sys_rst_n), 32'h1);
      wr(12'h008, 32'h02);
      rd_chk(12'h000, 32'h08);
      wait_for(1'b0, 1'b0, 200);
      wait_for(1'b0, 1'b1, 200);
      rd_chk(12'h004, 32'h08);
      dog_off();
      fuses.always_on <= 1'b1;
      @(posedge pclk);
      rd_chk(12'h000, 32'h08);
      wr(12'h000, 32'h40);
      rd_chk(12'h000, 32'h08);
      wait_for(1'b0, 1'b0, 200);
      fuses.always_on <= 1'b0;
      wait_for(1'b0, 1'b1, 200);
      dog_off();
      // pin, test chain and low supply, each with its own start-up code
      for (int s = 0; s < 3; s++) begin
         fuses.startup_time <= 2'(s);
         fuses.low_supply_level <= 3'h0;
         rst_pin_n <= (s != 0);
         jtag_reset <= (s == 1);
         bod_low <= (s == 2);
         #1;
         chk(32'(sys_rst_n), 32'h0);
         repeat (5) @(posedge pclk);
         rst_pin_n <= 1'b1;
         jtag_reset <= 1'b0;
         bod_low <= 1'b0;
         n = 0;
         lo = 2 + (2 << (2 * s));
         while (sys_rst_n !== 1'b1 && n < 100) begin
            @(posedge pclk);
            n++;
         end
         chk(32'(n >= lo && n <= lo + 2), 32'h1);
         @(posedge pclk);
      end
      rd_chk(12'h004, 32'h16);
      fuses.low_supply_level <= 3'h7;
      bod_low <= 1'b1;
      repeat (5) @(posedge pclk);
      chk(32'(sys_rst_n), 32'h1);
      bod_low <= 1'b0;
      presetn <= 1'b0;
      #1;
      chk(32'(sys_rst_n), 32'h0);
      @(posedge pclk);
      presetn <= 1'b1;
      wait_for(1'b0, 1'b1, 200);
      rd_chk(12'h004, 32'h01);
      chk(vec_n, 32'd8);
      close_out();
   end

   initial begin
      #(20000 * 8);
      err_count++;
      $display("ERROR %0t: run did not finish", $time);
      close_out();
   end
endmodule
